// [rtl/startup_seq_regs.vh]
`ifndef STARTUP_SEQ_REGS_VH
`define STARTUP_SEQ_REGS_VH
// register byte addresses
`define CTRL_ADDR 32'h00
`define STAT_ADDR 32'h04
`define RFR_ADDR 32'h08
// control register fields
`define CTRL_SWEN_BIT 0
`define CTRL_RESET 32'h00000001
// status register fields
`define STAT_STATE_LSB 0
`define STAT_DONE_BIT 4
`define STAT_EXTREF_BIT 5
`define STAT_OCEN_BIT 6
`define STAT_HOLD_BIT 7
// timing
`define CLK_PERIOD_NS 8
`define BLANK_NS 120
`define BLANK_CYC ((`BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_CYC ((`BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FULL_DUTY_CYCLES 64
`define HOLD_PULSES 2
// axi response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// [rtl/buck_startup_fault_sequencer.v]
// Summary of operation
// - enable low disables the converter
// - shutdown discharges soft-start, drives both low
// - charge source only after both supplies good
// - reference ramp starts above soft-start 1V
// - init: both gate drives held off
// - keep charging soft-start up to 4V
// - internal reference ramps over 1V..3V window
// - external reference ramps from 1V onward
// - drivers held until two pwm pulses seen
// - low-side switch turns on first
// - done output asserted at 4V
// - done cleared on disable, reset, overcurrent
// - 64 full-duty cycles force low-side refresh
// - overcurrent detection enabled with drivers
// - 120ns blanking with a 120ns filter running in parallel
// - fault disables drives, discharges soft-start
// - fault at 4V discharges immediately
// - fault during soft-start waits for 4V
// - restart at 0V, repeat as hiccup
// - reference select sampled at enable
`include "startup_seq_regs.vh"
`default_nettype none
module buck_startup_fault_sequencer #(
   parameter HOLD_PULSES = `HOLD_PULSES,
   parameter FULL_DUTY_CYCLES = `FULL_DUTY_CYCLES
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // comparator flags, already synchronous to aclk
   input wire enable_in,
   input wire vcc_good,
   input wire driver_supply_good,
   input wire ss_above_1v,
   input wire ss_above_3v,
   input wire ss_above_4v,
   input wire ss_near_0v,
   input wire external_reference_low,
   input wire overcurrent_cmp,
   // modulator interface
   input wire pwm_in,
   input wire cycle_start,
   // drive and analog control outputs
   output wire high_side_drive,
   output wire low_side_drive,
   output wire drivers_hold,
   output wire ss_charge_en,
   output wire ss_discharge_en,
   output wire ref_ramp_en,
   output wire ref_internal_window,
   output wire ref_use_external,
   output wire overcurrent_fault,
   // open-drain done pin
   output wire softstart_complete_o,
   output wire softstart_complete_oe
);

   // sequencer states
   localparam ST_OFF = 3'd0;
   localparam ST_CHARGE = 3'd1;
   localparam ST_RUN = 3'd2;
   localparam ST_FAULT_WAIT = 3'd3;
   localparam ST_DISCHARGE = 3'd4;
   localparam integer BLANK_INT = `BLANK_CYC;
   localparam integer FILT_INT = `FILT_CYC;
   localparam [5:0] BLANK_CYC = BLANK_INT[5:0]; // counters are only 6 bits wide
   localparam [5:0] FILT_CYC = FILT_INT[5:0];

   // axi state
   reg aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
   reg [31:0] awaddr_ff, wdata_ff, rdata_ff;
   reg [3:0] wstrb_ff;
   reg [1:0] bresp_ff, rresp_ff;
   reg swen_ff; // software enable, gated with the pin
   reg [15:0] refresh_cnt_ff; // counts bootstrap refreshes

   // sequencer state
   reg [2:0] state_ff, nxt_state;
   reg done_ff; // done flag behind the open-drain pin
   reg extref_ff; // reference choice latched at enable
   reg hold_ff; // drivers tri-stated
   reg [1:0] pulse_cnt_ff; // pwm pulses seen in hold
   reg pwm_d_ff;
   reg first_low_ff; // low side forced on after release
   reg [6:0] full_cnt_ff; // consecutive full-duty cycles
   reg refresh_ff; // low-side refresh half cycle
   reg cyc_pwm_low_ff; // pwm went low during this cycle
   reg [11:0] per_cnt_ff; // clocks since the last cycle start
   reg [11:0] per_len_ff; // length of the last switching period
   reg [5:0] blank_cnt_ff, filt_cnt_ff;
   reg hs_d_ff;
   reg oc_fault_ff;

   wire en = enable_in & swen_ff;
   wire supplies_ok = vcc_good & driver_supply_good;
   wire active = (state_ff == ST_CHARGE) || (state_ff == ST_RUN);
   wire pwm_rise = pwm_in & ~pwm_d_ff;
   wire oc_detect;

   // axi write path: address and data taken in either order
   assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // write channel registers, response once both halves are in
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         awaddr_ff <= 32'h0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         bresp_ff <= `RESP_OKAY;
         swen_ff <= 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (aw_got_ff && w_got_ff && !bvalid_ff) begin
            // commit: only the control word is writable
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            // full-word decode, the same as the read side
            if (awaddr_ff == `CTRL_ADDR) begin
               bresp_ff <= `RESP_OKAY;
               if (wstrb_ff[0]) begin
                  swen_ff <= wdata_ff[`CTRL_SWEN_BIT];
               end
            end else if (awaddr_ff == `STAT_ADDR) begin
               bresp_ff <= `RESP_OKAY; // read-only, write ignored
            end else if (awaddr_ff == `RFR_ADDR) begin
               bresp_ff <= `RESP_OKAY;
            end else begin
               bresp_ff <= `RESP_SLVERR;
            end
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // read channel: one cycle from address to data
   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= `RESP_OKAY;
         rdata_ff <= 32'h0;
         if (s_axi_araddr == `CTRL_ADDR) begin
            rdata_ff[`CTRL_SWEN_BIT] <= swen_ff;
         end else if (s_axi_araddr == `STAT_ADDR) begin
            rdata_ff[`STAT_STATE_LSB +: 3] <= state_ff;
            rdata_ff[`STAT_DONE_BIT] <= done_ff;
            rdata_ff[`STAT_EXTREF_BIT] <= extref_ff;
            rdata_ff[`STAT_OCEN_BIT] <= active & ~hold_ff;
            rdata_ff[`STAT_HOLD_BIT] <= hold_ff;
         end else if (s_axi_araddr == `RFR_ADDR) begin
            rdata_ff[15:0] <= refresh_cnt_ff;
         end else begin
            rresp_ff <= `RESP_SLVERR; // unmapped
         end
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // next-state logic of the start-up and hiccup sequencer
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF: begin
            if (en && supplies_ok) begin
               nxt_state = ST_CHARGE;
            end
         end
         ST_CHARGE: begin
            if (oc_detect) begin
               // fault mid ramp: keep charging until 4V first
               nxt_state = ss_above_4v ? ST_DISCHARGE : ST_FAULT_WAIT;
            end else if (ss_above_4v) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (oc_detect) begin
               nxt_state = ST_DISCHARGE;
            end
         end
         ST_FAULT_WAIT: begin
            if (ss_above_4v) begin
               nxt_state = ST_DISCHARGE;
            end
         end
         ST_DISCHARGE: begin
            if (ss_near_0v) begin
               nxt_state = ST_CHARGE;
            end
         end
         default: nxt_state = ST_OFF;
      endcase
      // disable or supply loss always wins
      if (!en || !supplies_ok) begin
         nxt_state = ST_OFF;
      end
   end

   // sequencer, hold-off, done flag and reference choice
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_OFF;
         done_ff <= 1'b0;
         extref_ff <= 1'b0;
         hold_ff <= 1'b1;
         pulse_cnt_ff <= 2'd0;
         pwm_d_ff <= 1'b0;
         first_low_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pwm_d_ff <= pwm_in;
         // latch the reference choice at the enable edge
         if (state_ff == ST_OFF && nxt_state == ST_CHARGE) begin
            extref_ff <= external_reference_low;
         end
         // done: set at 4V while running, cleared on any stop
         if (nxt_state == ST_OFF || oc_detect || state_ff == ST_FAULT_WAIT ||
             state_ff == ST_DISCHARGE) begin
            done_ff <= 1'b0;
         end else if (active && ss_above_4v) begin
            done_ff <= 1'b1;
         end
         // each new soft-start re-arms the hold-off
         if (nxt_state != ST_CHARGE && nxt_state != ST_RUN) begin
            hold_ff <= 1'b1;
            pulse_cnt_ff <= 2'd0;
            first_low_ff <= 1'b0;
         end else if (hold_ff && pwm_rise) begin
            if (pulse_cnt_ff == HOLD_PULSES - 1) begin
               hold_ff <= 1'b0;
               first_low_ff <= 1'b1;
            end
            pulse_cnt_ff <= pulse_cnt_ff + 2'd1;
         end else if (first_low_ff && cycle_start) begin
            first_low_ff <= 1'b0; // bootstrap got one full cycle
         end
      end
   end

   // period measure, so a refresh can end half way through a cycle
   // limitation: periods beyond 4095 clocks alias and end the refresh early
   always @(posedge aclk) begin
      if (!aresetn) begin
         per_cnt_ff <= 12'h0;
         per_len_ff <= 12'h0;
      end else if (cycle_start) begin
         per_cnt_ff <= 12'h1;
         per_len_ff <= per_cnt_ff;
      end else begin
         per_cnt_ff <= per_cnt_ff + 12'h1;
      end
   end

   // full-duty watch: a cycle with pwm never low counts
   always @(posedge aclk) begin
      if (!aresetn) begin
         full_cnt_ff <= 7'd0;
         refresh_ff <= 1'b0;
         cyc_pwm_low_ff <= 1'b0;
         refresh_cnt_ff <= 16'h0;
      end else if (!active || hold_ff) begin
         full_cnt_ff <= 7'd0;
         refresh_ff <= 1'b0;
         cyc_pwm_low_ff <= 1'b0;
      end else if (cycle_start) begin
         cyc_pwm_low_ff <= ~pwm_in;
         if (cyc_pwm_low_ff) begin
            full_cnt_ff <= 7'd0;
            refresh_ff <= 1'b0;
         end else if (full_cnt_ff == FULL_DUTY_CYCLES - 1) begin
            // refresh starts here; it ends half a period on, or at a pwm fall
            full_cnt_ff <= 7'd0;
            refresh_ff <= 1'b1;
            refresh_cnt_ff <= refresh_cnt_ff + 16'h1;
         end else begin
            full_cnt_ff <= full_cnt_ff + 7'd1;
            refresh_ff <= 1'b0;
         end
      end else begin
         if (!pwm_in) begin
            cyc_pwm_low_ff <= 1'b1;
         end
         // at true full duty pwm never falls, so the half period ends it
         if (refresh_ff && (!pwm_in || per_cnt_ff == per_len_ff[11:1])) begin
            refresh_ff <= 1'b0;
         end
      end
   end

   // overcurrent: blank after high-side turn-on, filter counting alongside
   always @(posedge aclk) begin
      if (!aresetn) begin
         hs_d_ff <= 1'b0;
         blank_cnt_ff <= 6'd0;
         filt_cnt_ff <= 6'd0;
         oc_fault_ff <= 1'b0;
      end else begin
         hs_d_ff <= high_side_drive;
         if (high_side_drive && !hs_d_ff) begin
            blank_cnt_ff <= BLANK_CYC;
         end else if (blank_cnt_ff != 6'd0) begin
            blank_cnt_ff <= blank_cnt_ff - 6'd1;
         end
         // filter runs in parallel with the blanking window
         if (!overcurrent_cmp || !high_side_drive) begin
            filt_cnt_ff <= 6'd0;
         end else if (filt_cnt_ff != FILT_CYC) begin
            filt_cnt_ff <= filt_cnt_ff + 6'd1;
         end
         oc_fault_ff <= oc_detect | (oc_fault_ff & state_ff != ST_CHARGE & nxt_state != ST_OFF);
      end
   end

   // detection only armed once drivers are released
   assign oc_detect = active && !hold_ff && blank_cnt_ff == 6'd0 &&
                      filt_cnt_ff == FILT_CYC;

   // drives: off in shutdown, hold and fault; low side leads
   wire drive_ok = active & ~hold_ff;
   assign high_side_drive = drive_ok & pwm_in & ~first_low_ff & ~refresh_ff;
   assign low_side_drive = drive_ok & (~pwm_in | first_low_ff | refresh_ff);
   assign drivers_hold = ~drive_ok;
   // soft-start current control
   assign ss_charge_en = state_ff == ST_CHARGE || state_ff == ST_RUN ||
                         state_ff == ST_FAULT_WAIT;
   assign ss_discharge_en = state_ff == ST_OFF || state_ff == ST_DISCHARGE;
   // reference ramp window
   assign ref_ramp_en = active & ss_above_1v;
   assign ref_internal_window = active & ~extref_ff & ss_above_1v & ~ss_above_3v;
   assign ref_use_external = extref_ff;
   assign overcurrent_fault = oc_fault_ff;
   // open drain: pull low unless done
   assign softstart_complete_o = 1'b0;
   assign softstart_complete_oe = ~done_ff;

endmodule
`default_nettype wire

// [testbench/buck_seq_assertions.sv]
`default_nettype none
module buck_seq_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // flags into the sequencer
   input wire logic enable_in,
   input wire logic vcc_good,
   input wire logic driver_supply_good,
   input wire logic ss_above_1v,
   input wire logic ss_above_4v,
   input wire logic ss_near_0v,
   input wire logic overcurrent_cmp,
   // sequencer outputs
   input wire logic high_side_drive,
   input wire logic low_side_drive,
   input wire logic drivers_hold,
   input wire logic ss_charge_en,
   input wire logic ss_discharge_en,
   input wire logic ref_ramp_en,
   input wire logic overcurrent_fault,
   input wire logic softstart_complete_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // run of cycles with a trip while the upper switch is on; saturates, never wraps
   logic [4:0] trip_cnt_ff;
   always @(posedge aclk) begin
      if (!aresetn || !(overcurrent_cmp && high_side_drive)) trip_cnt_ff <= 5'h00;
      else if (trip_cnt_ff != 5'h1f) trip_cnt_ff <= trip_cnt_ff + 5'h01;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_off_quiet:
      assert property (!enable_in |=> !high_side_drive && !low_side_drive) else $error("drive on");
   a_off_done_clear:
      assert property (!enable_in |=> softstart_complete_oe) else $error("done while off");
   a_charge_supply:
      assert property ($rose(ss_charge_en) |-> $past(vcc_good && driver_supply_good))
      else $error("charge without supplies");
   a_ramp_above_1v:
      assert property ($rose(ref_ramp_en) |-> ss_above_1v || $past(ss_above_1v))
      else $error("ramp below 1v");
   a_hold_quiet:
      assert property (drivers_hold |-> !high_side_drive && !low_side_drive) else $error("hold");
   a_done_at_4v:
      assert property ($fell(softstart_complete_oe) |-> $past(ss_above_4v)) else $error("early done");
   a_fault_done_clear:
      assert property ($rose(overcurrent_fault) |-> softstart_complete_oe) else $error("done kept");
   a_fault_quiet:
      assert property (overcurrent_fault |-> !high_side_drive && !low_side_drive)
      else $error("drive in fault");
   a_oc_armed:
      assert property ($rose(overcurrent_fault) |-> !$past(drivers_hold)) else $error("oc in hold");
   a_oc_filter:
      assert property ($rose(overcurrent_fault) |-> $past(trip_cnt_ff) >= 5'h0d)
      else $error("trip too short");
   a_sink_at_4v:
      assert property ($rose(ss_discharge_en) && $past(enable_in) |-> $past(ss_above_4v))
      else $error("sink below 4v");
   a_restart_0v:
      assert property ($fell(ss_discharge_en) && $past(overcurrent_fault) |-> $past(ss_near_0v))
      else $error("restart early");
   c_fault: cover property ($rose(overcurrent_fault));
   c_done: cover property ($fell(softstart_complete_oe));
   c_release: cover property ($fell(drivers_hold) ##1 low_side_drive);
endmodule
bind buck_startup_fault_sequencer buck_seq_checker chk_i (.*);
`default_nettype wire

// [testbench/power_stage_model.sv]
`default_nettype none
module power_stage_model (
   // clock
   input wire logic aclk,
   // sequencer commands
   input wire logic ss_charge_en,
   input wire logic ss_discharge_en,
   input wire logic high_side_drive,
   // bench controls: full duty, standing overload
   input wire logic full_duty,
   input wire logic oc_force,
   // comparator flags and modulator
   output logic ss_above_1v,
   output logic ss_above_3v,
   output logic ss_above_4v,
   output logic ss_near_0v,
   output logic pwm_in,
   output logic cycle_start,
   output logic overcurrent_cmp
);
   timeunit 1ns;
   timeprecision 1ps;
   // soft-start node in 10 mv steps; the sink is faster than the source
   int ss_lvl = 0;
   // free-running modulator phase, 32 clocks a period
   logic [4:0] phase = 5'h00;
   always @(posedge aclk) begin
      phase <= phase + 5'h01;
      if (ss_discharge_en) ss_lvl <= (ss_lvl > 20) ? ss_lvl - 20 : 0;
      // slow enough that a restart can trip before the node reaches 4v
      else if (ss_charge_en && ss_lvl < 420) ss_lvl <= ss_lvl + 2;
   end
   // flags move only at clock edges, as synchronised comparators would
   assign ss_above_1v = ss_lvl >= 100;
   assign ss_above_3v = ss_lvl >= 300;
   assign ss_above_4v = ss_lvl >= 400;
   assign ss_near_0v = ss_lvl == 0;
   // pulse of 20 clocks leaves room for the 15-clock trip filter
   assign pwm_in = full_duty || phase < 5'h14;
   assign cycle_start = phase == 5'h00;
   // a trip only means something while the upper switch conducts
   assign overcurrent_cmp = oc_force && high_side_drive;
endmodule
`default_nettype wire

// [testbench/buck_startup_fault_sequencer_bench.sv]
`include "startup_seq_regs.vh"
`default_nettype none
module buck_startup_fault_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // clock, reset and bus master side
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   // pins held by the bench
   logic enable_in = 1'h0, vcc_good = 1'h1, driver_supply_good = 1'h0;
   logic external_reference_low = 1'h0;
   logic full_duty = 1'h0, oc_force = 1'h0;
   // partner and design outputs
   logic ss_above_1v, ss_above_3v, ss_above_4v, ss_near_0v, pwm_in, cycle_start;
   logic overcurrent_cmp, high_side_drive, low_side_drive, drivers_hold, ss_charge_en;
   logic ss_discharge_en, ref_ramp_en, ref_internal_window, ref_use_external;
   logic overcurrent_fault, softstart_complete_o, softstart_complete_oe;
   int n_fail = 0, checks = 0, pulses = 0;
   logic pwm_d = 1'h0;
   logic [31:0] rd;
   logic [1:0] rsp;
   time t0;
   // register rows: write flag, address, data, read mask, response
   typedef struct {logic wr; logic [31:0] a, d, m; logic [1:0] r;} row_t;
   row_t rows [7] = '{
      '{1'h0, `CTRL_ADDR, 32'h1, 32'hffffffff, `RESP_OKAY},
      '{1'h0, `STAT_ADDR, 32'h0, 32'h7, `RESP_OKAY},
      '{1'h1, `STAT_ADDR, 32'hff, 32'h0, `RESP_OKAY},
      '{1'h0, `STAT_ADDR, 32'h0, 32'h7, `RESP_OKAY},
      '{1'h0, 32'hc, 32'h0, 32'hffffffff, `RESP_SLVERR},
      '{1'h1, 32'hc, 32'h5, 32'h0, `RESP_SLVERR},
      '{1'h1, `CTRL_ADDR, 32'h1, 32'h0, `RESP_OKAY}};
   buck_startup_fault_sequencer #(.FULL_DUTY_CYCLES(4)) DUT (.*);
   power_stage_model stage_i (.*);
   initial forever #4 aclk = ~aclk;
   // pwm rises since the soft-start sink last let go
   always @(posedge aclk) begin
      pwm_d <= pwm_in;
      if (ss_discharge_en) pulses <= 0;
      else if (pwm_in && !pwm_d) pulses <= pulses + 1;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // conditions the sequence waits on
   function automatic bit hit(input int s);
      case (s)
         0: return ss_charge_en === 1'h1;
         1: return !drivers_hold && (low_side_drive || high_side_drive);
         2: return softstart_complete_oe === 1'h0;
         3: return low_side_drive === 1'h1;
         4: return overcurrent_fault === 1'h1;
         5: return overcurrent_fault === 1'h0;
         6: return ref_ramp_en === 1'h1;
         default: return low_side_drive === 1'h0;
      endcase
   endfunction
   // bounded wait; running out counts as a mismatch
   task automatic wt(input int s);
      int k;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (!hit(s) && k < 3000);
      chk({31'h0, hit(s)}, 32'h1);
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      chk({high_side_drive, low_side_drive, softstart_complete_o, ss_discharge_en}, 32'h1);
      chk(softstart_complete_oe, 32'h1);
      aresetn <= 1'h1;
      foreach (rows[i]) begin
         if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rsp);
         else begin
            axi_rd(rows[i].a, rd, rsp);
            chk(rd & rows[i].m, rows[i].d);
         end
         chk(rsp, rows[i].r);
      end
      // enabled but the driver supply still low: no charging
      enable_in <= 1'h1;
      repeat (10) @(posedge aclk);
      chk(ss_charge_en, 32'h0);
      driver_supply_good <= 1'h1;
      wt(0);
      chk({ref_ramp_en, ref_use_external, drivers_hold}, 32'h1);
      wt(1);
      chk(pulses >= 2, 32'h1);
      chk({high_side_drive, low_side_drive}, 32'h1);
      chk(ref_internal_window, 32'h1);
      wt(2);
      chk({ref_internal_window, ref_ramp_en}, 32'h1);
      axi_rd(`STAT_ADDR, rd, rsp);
      chk(rd & 32'h17, 32'h12);
      // full duty on, timing starts once the low side has let go
      full_duty <= 1'h1;
      wt(7);
      t0 = $time;
      wt(3);
      chk(($time - t0) >= 1024 && ($time - t0) <= 1296, 32'h1);
      t0 = $time;
      wt(7);
      chk(($time - t0) >= 96 && ($time - t0) <= 160, 32'h1);
      full_duty <= 1'h0;
      oc_force <= 1'h1;
      wt(4);
      chk({softstart_complete_oe, ss_discharge_en}, 32'h3);
      wt(5);
      wt(4);
      chk({ss_charge_en, ss_discharge_en}, 32'h2);
      oc_force <= 1'h0;
      wt(5);
      wt(2);
      enable_in <= 1'h0;
      repeat (2) @(posedge aclk);
      chk({softstart_complete_oe, ss_discharge_en, high_side_drive, low_side_drive}, 32'hc);
      external_reference_low <= 1'h1;
      repeat (30) @(posedge aclk);
      enable_in <= 1'h1;
      wt(0);
      chk(ref_use_external, 32'h1);
      wt(6);
      chk({ref_internal_window, ss_above_1v}, 32'h1);
      complete_run;
   end
   // watchdog, well beyond the expected run length
   initial begin
      #200000;
      n_fail++;
      complete_run;
   end
endmodule
`default_nettype wire
